//--- logic/rtcfg_pkg.sv
// constants, field layouts and carrier types for the retimer lane configuration block
package rtcfg_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register offsets
	localparam logic [7:0] REG_CTRL = 8'h08;
	localparam logic [7:0] REG_MODE = 8'h0A;
	localparam logic [7:0] REG_OUTCTL = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_ERR0 = 8'h11;
	localparam logic [7:0] REG_ERR1 = 8'h12;
	localparam logic [7:0] REG_ERR2 = 8'h13;
	localparam logic [7:0] REG_EYE_SEL = 8'h14;
	localparam logic [7:0] REG_EYE_DATA = 8'h15;

	// control register fields
	localparam int CTRL_REG_CFG_BIT = 0;
	localparam int CTRL_SIGDET_BIT = 1;
	localparam int CTRL_ARC_OFF_BIT = 2;
	localparam int CTRL_EQ_ADAPT_BIT = 3;
	localparam int CTRL_EQ_HIGH_BIT = 4;
	localparam int CTRL_PATTERN_BIT = 5;

	// output control fields and codes
	localparam int OUT_DEEMPH_LSB = 0;
	localparam int OUT_SWING_LSB = 5;
	localparam logic [1:0] DEEMPH_2DB_CODE = 2'h1;
	localparam logic [2:0] SWING_HIGH_CODE = 3'h3;
	localparam logic [2:0] SWING_NOMINAL = 3'h0;

	// function mode field codes
	localparam logic [1:0] MODE_REDRIVER = 2'h0;
	localparam logic [1:0] MODE_RETIMER = 2'h1;
	localparam logic [1:0] MODE_AUTO = 2'h3;

	// reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] MODE_RESET = 8'h03;
	localparam logic [7:0] OUTCTL_RESET = 8'h00;
	localparam logic [7:0] EYE_SEL_RESET = 8'h00;

	// local port address: top address minus the two address straps
	localparam logic [6:0] LOCAL_ADDR_TOP = 7'h5E;

	// rate classes and three-level strap codes {low seen, high seen}
	localparam logic [1:0] RATE_NONE = 2'h0;
	localparam logic [1:0] RATE_LOW = 2'h1;
	localparam logic [1:0] RATE_MID = 2'h2;
	localparam logic [1:0] RATE_HIGH = 2'h3;
	localparam logic [1:0] STRAP_FLOAT = 2'h0;
	localparam logic [1:0] STRAP_HIGH = 2'h1;
	localparam logic [1:0] STRAP_LOW = 2'h2;

	// timing
	localparam int CLK_FREQ_MHZ = 125;
	localparam int RX_CLK_DIV = 64;
	localparam int BITS_PER_PIXEL_CLK = 10;
	localparam int RATE_MIN_MBPS = 250;
	localparam int RATE_RETIMER_MBPS = 1000;
	localparam int RATE_TERM_MBPS = 2000;
	localparam int RATE_WINDOW_DEFAULT = 8192;
	localparam logic [3:0] STRAP_SETTLE_CYC = 4'h4;

	////////////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic rx_term_connect;
		logic cdr_enable;
		logic outputs_hiz;
		logic retimer_mode;
		logic tx_term_enable;
		logic eq_adaptive;
		logic eq_gain_high;
		logic deemph_2db;
		logic [2:0] output_swing;
		logic pattern_select;
	} rtcfg_lane_ctrl_t;

	typedef struct packed {
		logic [2:0] bit_val;
		logic [2:0] bit_valid;
	} rtcfg_rx_bits_t;

	typedef struct packed {
		logic [2:0][7:0] sample;
	} rtcfg_eye_t;

	typedef enum logic [5:0] {
		PORT_IDLE = 6'h01,
		PORT_ADDR = 6'h02,
		PORT_ACK = 6'h04,
		PORT_WRITE = 6'h08,
		PORT_READ = 6'h10,
		PORT_RACK = 6'h20
	} rtcfg_port_state_t;

endpackage : rtcfg_pkg

//--- logic/rtcfg_sync.sv
// two-flop synchroniser for pins entering the clock domain
`timescale 1ns/1ns
module rtcfg_sync import rtcfg_pkg::*; #(
	parameter int WIDTH = 11
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// asynchronous pins and their synchronised copy
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			meta <= '0;
			sync_out <= '0;
		end else begin
			meta <= async_in;
			sync_out <= meta;
		end
	end

endmodule : rtcfg_sync

//--- logic/rtcfg_lane_checker.sv
// self-synchronising pattern checker with saturating error count for one lane
`timescale 1ns/1ns
module rtcfg_lane_checker import rtcfg_pkg::*; (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// sampled lane bits
	input wire logic bit_in,
	input wire logic bit_valid_in,
	// count control and result
	input wire logic clear_in,
	output logic [7:0] count_out
);

	logic [6:0] hist;
	logic [2:0] primed;
	logic err;
	logic [7:0] next_count;

	// x^7+x^6+1: each bit predicted from the last seven, no seed to align
	assign err = bit_valid_in && (primed == 3'h7) && (bit_in != (hist[6] ^ hist[5]));
	// a clear never swallows an error of the same cycle
	assign next_count = clear_in ? {7'h00, err} :
		(err && count_out != 8'hFF) ? count_out + 8'h01 : count_out;

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			hist <= 7'h00;
			primed <= 3'h0;
			count_out <= 8'h00;
		end else begin
			if (bit_valid_in) begin
				hist <= {hist[5:0], bit_in};
				primed <= (primed == 3'h7) ? primed : primed + 3'h1;
			end
			count_out <= next_count;
		end
	end

	err_count_a: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		err && !clear_in && count_out != 8'hFF |=> count_out == $past(count_out) + 8'h01)
		else $error("lane error not counted");

endmodule : rtcfg_lane_checker

//--- logic/rtcfg_core.sv
// lane configuration, rate detection and local register port for the retimer
`timescale 1ns/1ns
module rtcfg_core import rtcfg_pkg::*; #(
	parameter int RATE_WINDOW_CYCLES = RATE_WINDOW_DEFAULT
) (
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// local two-wire register port, data line open drain
	input wire logic reg_clock_in,
	input wire logic reg_data_in,
	output logic reg_data_out,
	output logic reg_data_oe_out,
	input wire logic address_select_pin_in,
	// straps and select pins, three-level straps as {low seen, high seen}
	input wire logic [1:0] equalizer_select_strap_in,
	input wire logic [1:0] transmit_termination_strap_in,
	input wire logic deemphasis_select_pin_in,
	input wire logic signal_detect_enable_pin_in,
	// divided input clock lane
	input wire logic rx_clock_div_in,
	// sampled lane data and eye samples
	input wire rtcfg_rx_bits_t rx_bits_in,
	input wire rtcfg_eye_t eye_sample_in,
	output logic [1:0] eye_lane_out,
	output logic eye_advance_out,
	// audio return
	input wire logic audio_input_pin_in,
	output logic audio_return_output_out,
	output logic audio_return_output_oe_out,
	// lane controls and test pattern
	output rtcfg_lane_ctrl_t lane_ctrl_out,
	output logic test_pattern_out
);

	localparam int EDGE_DEN = BITS_PER_PIXEL_CLK * RX_CLK_DIV * CLK_FREQ_MHZ;
	localparam logic [15:0] EDGE_VALID = 16'((RATE_MIN_MBPS * RATE_WINDOW_CYCLES) / EDGE_DEN);
	localparam logic [15:0] EDGE_RETIMER = 16'((RATE_RETIMER_MBPS * RATE_WINDOW_CYCLES) / EDGE_DEN);
	localparam logic [15:0] EDGE_TERM = 16'((RATE_TERM_MBPS * RATE_WINDOW_CYCLES) / EDGE_DEN);
	localparam logic [15:0] WINDOW_LAST = 16'(RATE_WINDOW_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisation
	logic [10:0] pins_s;
	logic scl_s, sda_s, rxclk_s, audio_s, a1_s, deemph_pin_s, sigdet_pin_s;
	logic [1:0] eq_strap_s, term_strap_s;
	logic scl_q, sda_q, rxclk_q;

	rtcfg_sync #(.WIDTH(11)) u_sync (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.async_in({reg_clock_in, reg_data_in, rx_clock_div_in, audio_input_pin_in, address_select_pin_in,
			deemphasis_select_pin_in, signal_detect_enable_pin_in, equalizer_select_strap_in,
			transmit_termination_strap_in}),
		.sync_out(pins_s)
	);

	assign {scl_s, sda_s, rxclk_s, audio_s, a1_s, deemph_pin_s, sigdet_pin_s} = pins_s[10:4];
	assign eq_strap_s = pins_s[3:2];
	assign term_strap_s = pins_s[1:0];

	// edge history from the synchronised copies only
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			scl_q <= 1'h1;
			sda_q <= 1'h1;
			rxclk_q <= 1'h0;
		end else begin
			scl_q <= scl_s;
			sda_q <= sda_s;
			rxclk_q <= rxclk_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// strap capture after reset release, once the synchroniser has filled
	logic [3:0] settle;
	logic [1:0] eq_strap, term_strap;
	logic [1:0] eq_addr_bit;

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			settle <= 4'h0;
			eq_strap <= STRAP_FLOAT;
			term_strap <= STRAP_FLOAT;
		end else if (settle != STRAP_SETTLE_CYC) begin
			settle <= settle + 4'h1;
			eq_strap <= eq_strap_s;
			term_strap <= term_strap_s;
		end
	end

	// the equalizer strap doubles as the low address bit: only a high reads as one
	assign eq_addr_bit = {a1_s, eq_strap == STRAP_HIGH};

	////////////////////////////////////////////////////////////////////////////////
	// rate measurement over a fixed window of system clocks
	logic [15:0] win_cnt, edge_cnt;
	logic [1:0] rate_class, next_rate;
	logic win_end;

	assign win_end = (win_cnt == WINDOW_LAST);
	assign next_rate = (edge_cnt < EDGE_VALID) ? RATE_NONE :
		(edge_cnt < EDGE_RETIMER) ? RATE_LOW :
		(edge_cnt < EDGE_TERM) ? RATE_MID : RATE_HIGH;

	// class only moves at a window end, so one glitch cannot flip terminations
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			win_cnt <= 16'h0000;
			edge_cnt <= 16'h0000;
			rate_class <= RATE_NONE;
		end else begin
			win_cnt <= win_end ? 16'h0000 : win_cnt + 16'h0001;
			if (win_end) begin
				edge_cnt <= 16'h0000;
				rate_class <= next_rate;
			end else if (rxclk_s && !rxclk_q && edge_cnt != 16'hFFFF) begin
				edge_cnt <= edge_cnt + 16'h0001;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// local register port engine
	rtcfg_port_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shift, ptr, wr_addr, wr_data, rd_addr, read_mux;
	logic is_read, sub_pending, wr_pulse, rd_pulse;
	logic scl_rise, scl_fall, start_seen, stop_seen, byte_done;

	assign scl_rise = scl_s && !scl_q;
	assign scl_fall = !scl_s && scl_q;
	assign start_seen = scl_s && scl_q && sda_q && !sda_s;
	assign stop_seen = scl_s && scl_q && !sda_q && sda_s;
	assign byte_done = (bit_cnt == 4'h8);

	always_ff @(posedge clock_in) begin
		wr_pulse <= 1'h0;
		rd_pulse <= 1'h0;
		if (!rst_n_in) begin
			state <= PORT_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			ptr <= 8'h00;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
			rd_addr <= 8'h00;
			is_read <= 1'h0;
			sub_pending <= 1'h0;
			reg_data_oe_out <= 1'h0;
		end else if (start_seen) begin
			state <= PORT_ADDR;
			bit_cnt <= 4'h0;
			reg_data_oe_out <= 1'h0;
		end else if (stop_seen) begin
			state <= PORT_IDLE;
			reg_data_oe_out <= 1'h0;
		end else begin
			case (state)
				PORT_ADDR, PORT_WRITE: begin
					if (scl_rise && !byte_done) begin
						shift <= {shift[6:0], sda_s};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && byte_done && state == PORT_ADDR) begin
						if (shift[7:1] == LOCAL_ADDR_TOP - {5'h00, eq_addr_bit}) begin
							state <= PORT_ACK;
							reg_data_oe_out <= 1'h1;
							is_read <= shift[0];
							sub_pending <= !shift[0];
							if (shift[0]) begin
								ptr <= 8'h00;
							end
						end else begin
							state <= PORT_IDLE;
						end
					end else if (scl_fall && byte_done) begin
						state <= PORT_ACK;
						reg_data_oe_out <= 1'h1;
						sub_pending <= 1'h0;
						if (sub_pending) begin
							ptr <= shift;
						end else begin
							wr_pulse <= 1'h1;
							wr_addr <= ptr;
							wr_data <= shift;
							ptr <= ptr + 8'h01;
						end
					end
				end
				PORT_ACK: begin
					if (scl_fall && is_read) begin
						shift <= read_mux;
						reg_data_oe_out <= !read_mux[7];
						bit_cnt <= 4'h1;
						rd_pulse <= 1'h1;
						rd_addr <= ptr;
						ptr <= ptr + 8'h01;
						state <= PORT_READ;
					end else if (scl_fall) begin
						reg_data_oe_out <= 1'h0;
						bit_cnt <= 4'h0;
						state <= PORT_WRITE;
					end
				end
				PORT_READ: begin
					if (scl_fall && byte_done) begin
						reg_data_oe_out <= 1'h0;
						state <= PORT_RACK;
					end else if (scl_fall) begin
						shift <= {shift[6:0], 1'h0};
						reg_data_oe_out <= !shift[6];
						bit_cnt <= bit_cnt + 4'h1;
					end
				end
				PORT_RACK: begin
					if (scl_rise) begin
						state <= sda_s ? PORT_IDLE : PORT_ACK;
					end
				end
				default: begin
					state <= PORT_IDLE;
				end
			endcase
		end
	end

	// open drain: the line is only ever pulled low
	assign reg_data_out = 1'h0;

	////////////////////////////////////////////////////////////////////////////////
	// register file
	logic [7:0] ctrl_reg, mode_reg, outctl_reg, eye_sel_reg, status_reg, eye_data;
	logic [2:0][7:0] err_count;
	logic [2:0] err_clear;

	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			ctrl_reg <= CTRL_RESET;
			mode_reg <= MODE_RESET;
			outctl_reg <= OUTCTL_RESET;
			eye_sel_reg <= EYE_SEL_RESET;
		end else if (wr_pulse) begin
			ctrl_reg <= (wr_addr == REG_CTRL) ? wr_data : ctrl_reg;
			mode_reg <= (wr_addr == REG_MODE) ? wr_data : mode_reg;
			outctl_reg <= (wr_addr == REG_OUTCTL) ? wr_data : outctl_reg;
			eye_sel_reg <= (wr_addr == REG_EYE_SEL) ? wr_data : eye_sel_reg;
		end
	end

	function automatic logic [7:0] reg_mux(input logic [7:0] a, input logic [7:0] c, input logic [7:0] m,
			input logic [7:0] o, input logic [7:0] st, input logic [2:0][7:0] e, input logic [7:0] es,
			input logic [7:0] ed);
		case (a)
			REG_CTRL: reg_mux = c;
			REG_MODE: reg_mux = m;
			REG_OUTCTL: reg_mux = o;
			REG_STATUS: reg_mux = st;
			REG_ERR0: reg_mux = e[0];
			REG_ERR1: reg_mux = e[1];
			REG_ERR2: reg_mux = e[2];
			REG_EYE_SEL: reg_mux = es;
			REG_EYE_DATA: reg_mux = ed;
			default: reg_mux = 8'h00;
		endcase
	endfunction : reg_mux

	// eye samples of the selected lane; lane code 3 reads as zero
	assign eye_data = (eye_sel_reg[1:0] == 2'h3) ? 8'h00 : eye_sample_in.sample[eye_sel_reg[1:0]];
	assign status_reg = {4'h0, rate_class, lane_ctrl_out.outputs_hiz, lane_ctrl_out.retimer_mode};
	assign read_mux = reg_mux(ptr, ctrl_reg, mode_reg, outctl_reg, status_reg, err_count, eye_sel_reg, eye_data);

	////////////////////////////////////////////////////////////////////////////////
	// per-lane error checkers, cleared by any write to their count register
	genvar lane;
	generate
		for (lane = 0; lane < 3; lane++) begin : g_lane
			assign err_clear[lane] = wr_pulse && (wr_addr == REG_ERR0 + 8'(lane));
			rtcfg_lane_checker u_check (
				.clock_in(clock_in),
				.rst_n_in(rst_n_in),
				.bit_in(rx_bits_in.bit_val[lane]),
				.bit_valid_in(rx_bits_in.bit_valid[lane]),
				.clear_in(err_clear[lane]),
				.count_out(err_count[lane])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// lane control decode
	logic reg_cfg, sigdet_en, clk_valid, standby, retimer, deemph_req;
	rtcfg_lane_ctrl_t next_ctrl;
	logic [6:0] lfsr;

	assign reg_cfg = ctrl_reg[CTRL_REG_CFG_BIT];
	assign sigdet_en = sigdet_pin_s || ctrl_reg[CTRL_SIGDET_BIT];
	assign clk_valid = (rate_class != RATE_NONE);
	assign standby = sigdet_en && !clk_valid;
	assign retimer = (mode_reg[1:0] == MODE_RETIMER) ||
		(mode_reg[1:0] == MODE_AUTO && rate_class >= RATE_MID);
	assign deemph_req = reg_cfg ? (outctl_reg[OUT_DEEMPH_LSB +: 2] == DEEMPH_2DB_CODE)
		: !deemph_pin_s;

	assign next_ctrl.rx_term_connect = !standby;
	assign next_ctrl.cdr_enable = retimer && !standby;
	assign next_ctrl.outputs_hiz = standby;
	assign next_ctrl.retimer_mode = retimer && !standby;
	// reserved low strap level treated like high: termination stays off
	assign next_ctrl.tx_term_enable = (term_strap == STRAP_FLOAT) && (rate_class == RATE_HIGH);
	assign next_ctrl.eq_adaptive = reg_cfg ? ctrl_reg[CTRL_EQ_ADAPT_BIT] : (eq_strap == STRAP_FLOAT);
	assign next_ctrl.eq_gain_high = next_ctrl.eq_adaptive ? (rate_class == RATE_HIGH)
		: reg_cfg ? ctrl_reg[CTRL_EQ_HIGH_BIT] : (eq_strap == STRAP_HIGH);
	assign next_ctrl.deemph_2db = deemph_req && retimer && !standby;
	assign next_ctrl.output_swing = reg_cfg ? outctl_reg[OUT_SWING_LSB +: 3] : SWING_NOMINAL;
	// the pattern only means something with a clock on the input lane
	assign next_ctrl.pattern_select = ctrl_reg[CTRL_PATTERN_BIT] && clk_valid && !standby;

	// outputs from flops; the audio path adds one flop after the synchroniser latency
	always_ff @(posedge clock_in) begin
		if (!rst_n_in) begin
			lane_ctrl_out <= '0;
			lfsr <= 7'h7F;
			test_pattern_out <= 1'h0;
			audio_return_output_out <= 1'h0;
			audio_return_output_oe_out <= 1'h0;
			eye_lane_out <= 2'h0;
			eye_advance_out <= 1'h0;
		end else begin
			lane_ctrl_out <= next_ctrl;
			lfsr <= {lfsr[5:0], lfsr[6] ^ lfsr[5]};
			test_pattern_out <= next_ctrl.pattern_select && lfsr[6];
			audio_return_output_out <= audio_s;
			audio_return_output_oe_out <= !ctrl_reg[CTRL_ARC_OFF_BIT];
			eye_lane_out <= eye_sel_reg[1:0];
			eye_advance_out <= rd_pulse && (rd_addr == REG_EYE_DATA);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	sequence s_window_close;
		win_end ##1 1'h1;
	endsequence

	standby_outputs_a: assert property (standby |=> lane_ctrl_out.outputs_hiz &&
		!lane_ctrl_out.cdr_enable && !lane_ctrl_out.rx_term_connect) else $error("standby not entered");
	active_term_a: assert property (sigdet_en && clk_valid |=> lane_ctrl_out.rx_term_connect)
		else $error("terminations not connected");
	eq_fixed_strap_a: assert property (!reg_cfg && eq_strap != STRAP_FLOAT |=>
		!lane_ctrl_out.eq_adaptive && lane_ctrl_out.eq_gain_high == $past(eq_strap == STRAP_HIGH))
		else $error("fixed equalizer gain wrong");
	// the release edge still samples reset state, so it starts no attempt
	eq_adaptive_a: assert property (rst_n_in && !reg_cfg && eq_strap == STRAP_FLOAT |=>
		lane_ctrl_out.eq_adaptive && lane_ctrl_out.eq_gain_high == $past(rate_class == RATE_HIGH))
		else $error("adaptive equalizer not selected");
	deemph_retimer_a: assert property (lane_ctrl_out.deemph_2db |-> lane_ctrl_out.retimer_mode)
		else $error("de-emphasis outside retimer mode");
	deemph_reg_a: assert property (reg_cfg && retimer && !standby &&
		outctl_reg[1:0] == DEEMPH_2DB_CODE |=> lane_ctrl_out.deemph_2db) else $error("de-emphasis code ignored");
	swing_reg_a: assert property (reg_cfg |=> lane_ctrl_out.output_swing == $past(outctl_reg[7:5]))
		else $error("swing code not applied");
	auto_redriver_a: assert property (mode_reg[1:0] == MODE_AUTO && rate_class == RATE_LOW
		|=> !lane_ctrl_out.retimer_mode && !lane_ctrl_out.cdr_enable) else $error("retimer below 1 Gbps");
	term_strap_a: assert property (term_strap != STRAP_FLOAT |=> !lane_ctrl_out.tx_term_enable)
		else $error("termination on with strap driven");
	term_rate_a: assert property (term_strap == STRAP_FLOAT |=>
		lane_ctrl_out.tx_term_enable == $past(rate_class == RATE_HIGH)) else $error("termination not by rate");
	rate_update_a: assert property (s_window_close |-> rate_class == $past(next_rate))
		else $error("rate class not updated");
	audio_follow_a: assert property (rst_n_in && !ctrl_reg[CTRL_ARC_OFF_BIT] |=> audio_return_output_oe_out &&
		audio_return_output_out == $past(audio_s)) else $error("audio return not forwarded");

endmodule : rtcfg_core

//--- dv/rtcfg_src_model.sv
// far-side video source model: divided clock lane and pseudo_random_test_pattern data lanes
`timescale 1ns/1ns
module rtcfg_src_model import rtcfg_pkg::*; (
	// clock and controls from the bench
	input wire logic clock_in,
	input wire logic [7:0] half_in,
	input wire logic [2:0] invert_in,
	// lanes toward the block
	output logic rx_clock_div_out,
	output rtcfg_rx_bits_t rx_bits_out
);
	////////////////////////////////////////
	logic [7:0] cnt = 8'h00;
	logic [6:0] pseudo_random_test_pattern = 7'h7F;
	wire logic wrap = (cnt + 8'h01 >= half_in);
	wire logic nbit = pseudo_random_test_pattern[6] ^ pseudo_random_test_pattern[5];
	initial rx_clock_div_out = 1'b0;
	initial rx_bits_out = '0;
	// clock lane stands still at half_in zero, as a source with no video
	always @(posedge clock_in) begin
		cnt <= wrap ? 8'h00 : cnt + 8'h01;
		if (half_in == 8'h00) begin
			rx_clock_div_out <= 1'b0;
		end else if (wrap) begin
			rx_clock_div_out <= !rx_clock_div_out;
		end
	end
	// inverting a lane turns every bit into an error
	// the pattern pauses with the clock lane so valid bits stay one unbroken sequence
	always @(posedge clock_in) begin
		if (half_in != 8'h00) pseudo_random_test_pattern <= {pseudo_random_test_pattern[5:0], nbit};
		rx_bits_out.bit_val <= {3{nbit}} ^ invert_in;
		rx_bits_out.bit_valid <= {3{half_in != 8'h00}};
	end
endmodule : rtcfg_src_model

//--- dv/tb_video_retimer_lane_config.sv
// self-checking bench for the retimer lane configuration block
`timescale 1ns/1ns
module tb_video_retimer_lane_config import rtcfg_pkg::*; ();
	////////////////////////////////////////
	logic clock_in = 1'b0;
	logic rst_n = 1'b0;
	logic scl = 1'b1;
	logic m_oe = 1'b0;
	logic [1:0] eq_strap = STRAP_FLOAT;
	logic [1:0] tt_strap = STRAP_FLOAT;
	logic de_pin = 1'b0;
	logic sd_pin = 1'b0;
	logic audio = 1'b0;
	logic aud_chk = 1'b0;
	logic [7:0] half = 8'h00;
	logic [2:0] inv = 3'h0;
	logic [7:0] dev = 8'hBC;
	logic [31:0] seed = 32'h66D4;
	logic [3:0] ah = 4'h0;
	logic [7:0] rb [32];
	logic [7:0] ph;
	logic any;
	logic [7:0] rates [3] = '{8'h08, 8'h20, 8'h60};
	logic [2:0] expt [3] = '{3'h7, 3'h4, 3'h0};
	rtcfg_eye_t eye = '0;
	rtcfg_rx_bits_t bits;
	rtcfg_lane_ctrl_t lc;
	logic [1:0] lane;
	logic rxclk, oe, arc, arc_oe, pat, adv;
	int n_adv = 0;
	wire logic sda = !(m_oe | oe);
	int mismatches = 0;
	int n_compared = 0;
	always #4 clock_in = !clock_in;
	// open-drain data line: low while either side pulls
	rtcfg_core #(.RATE_WINDOW_CYCLES(1024)) DUT (.clock_in(clock_in), .rst_n_in(rst_n), .reg_clock_in(scl),
		.reg_data_in(sda), .reg_data_out(), .reg_data_oe_out(oe), .address_select_pin_in(1'b0),
		.equalizer_select_strap_in(eq_strap), .transmit_termination_strap_in(tt_strap),
		.deemphasis_select_pin_in(de_pin), .signal_detect_enable_pin_in(sd_pin), .rx_clock_div_in(rxclk),
		.rx_bits_in(bits), .eye_sample_in(eye), .eye_lane_out(lane), .eye_advance_out(adv),
		.audio_input_pin_in(audio), .audio_return_output_out(arc), .audio_return_output_oe_out(arc_oe),
		.lane_ctrl_out(lc), .test_pattern_out(pat));
	rtcfg_src_model src (.clock_in(clock_in), .half_in(half), .invert_in(inv), .rx_clock_div_out(rxclk),
		.rx_bits_out(bits));
	////////////////////////////////////////
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
	endtask : tick
	task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp
	task automatic cbit(input string what, input logic exp, input logic got);
		cmp(what, {7'h00, exp}, {7'h00, got});
	endtask : cbit
	task automatic results;
		if (mismatches == 0 && n_compared > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : results
	// straps must stand before release, they are captured just after it
	task automatic reset(input logic [1:0] eqs, input logic [1:0] tts);
		rst_n <= 1'b0;
		eq_strap <= eqs;
		tt_strap <= tts;
		tick(16);
		rst_n <= 1'b1;
		tick(8);
	endtask : reset
	////////////////////////////////////////
	// two-wire master: data moves two clocks after the clock line falls
	task automatic sbit(input logic b, output logic r);
		tick(2);
		m_oe <= !b;
		tick(6);
		scl <= 1'b1;
		tick(8);
		r = sda;
		scl <= 1'b0;
	endtask : sbit
	task automatic start;
		tick(2);
		m_oe <= 1'b0;
		tick(6);
		scl <= 1'b1;
		tick(8);
		m_oe <= 1'b1;
		tick(8);
		scl <= 1'b0;
	endtask : start
	task automatic stop;
		tick(2);
		m_oe <= 1'b1;
		tick(6);
		scl <= 1'b1;
		tick(8);
		m_oe <= 1'b0;
		tick(8);
	endtask : stop
	task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--) sbit(d[i], r[i]);
		sbit(last, a);
	endtask : xfer
	task automatic wr(input logic [7:0] off, input logic [7:0] val);
		logic [7:0] r;
		logic a;
		logic [7:0] b [3];
		b = '{dev, off, val};
		start();
		foreach (b[i]) begin
			xfer(b[i], 1'b1, r, a);
			cbit("ack", 1'b0, a);
		end
		stop();
	endtask : wr
	task automatic rd(input int n);
		logic a;
		start();
		xfer(dev | 8'h01, 1'b1, rb[0], a);
		cbit("ack", 1'b0, a);
		for (int i = 0; i < n; i++) xfer(8'hFF, i == n - 1, rb[i], a);
		stop();
	endtask : rd
	////////////////////////////////////////
	// random audio stream; the return output trails it by three flops
	always @(posedge clock_in) begin
		seed <= lfsr(seed);
		audio <= seed[0];
		ah <= {ah[2:0], seed[0]};
		if (adv) n_adv <= n_adv + 1;
		if (aud_chk) cbit("audio", ah[3], arc);
	end
	initial begin
		tick(1);
		eye <= seed[23:0];
		reset(STRAP_FLOAT, STRAP_FLOAT);
		aud_chk <= 1'b1;
		cbit("arc_oe", 1'b1, arc_oe);
		cbit("eq_adapt", 1'b1, lc.eq_adaptive);
		tick(2200);
		cbit("hiz", 1'b0, lc.outputs_hiz);
		sd_pin <= 1'b1;
		inv <= 3'h2;
		tick(2200);
		cbit("standby", 1'b1, lc.outputs_hiz);
		cbit("cdr", 1'b0, lc.cdr_enable);
		for (int k = 0; k < 3; k++) begin
			half <= rates[k];
			tick(2200);
			cbit("retimer", expt[k][2], lc.retimer_mode);
			cbit("tx_term", expt[k][1], lc.tx_term_enable);
			cbit("eq_gain", expt[k][0], lc.eq_gain_high);
			cbit("deemph", expt[k][2], lc.deemph_2db);
			cbit("rx_term", 1'b1, lc.rx_term_connect);
			cbit("hiz", 1'b0, lc.outputs_hiz);
		end
		half <= 8'h08;
		de_pin <= 1'b1;
		tick(2200);
		cbit("deemph", 1'b0, lc.deemph_2db);
		sd_pin <= 1'b0;
		wr(REG_CTRL, 8'h02);
		half <= 8'h00;
		tick(2200);
		cbit("standby", 1'b1, lc.outputs_hiz);
		half <= 8'h08;
		tick(2200);
		wr(REG_CTRL, 8'h3B);
		wr(REG_OUTCTL, 8'h61);
		wr(REG_EYE_SEL, 8'h01);
		cbit("deemph", 1'b1, lc.deemph_2db);
		cmp("swing", 8'h03, {5'h00, lc.output_swing});
		cbit("eq_adapt", 1'b1, lc.eq_adaptive);
		cbit("eq_gain", 1'b1, lc.eq_gain_high);
		cmp("eye_lane", 8'h01, {6'h00, lane});
		ph = 8'h00;
		any = 1'b0;
		for (int i = 0; i < 40; i++) begin
			tick(1);
			ph = {ph[6:0], pat};
			any = any | pat;
			if (i > 8) cbit("pattern", ph[7] ^ ph[6], ph[0]);
		end
		cbit("pattern_live", 1'b1, any);
		cbit("pattern_sel", 1'b1, lc.pattern_select);
		rd(22);
		cmp("status", 8'h0D, rb[REG_STATUS]);
		cmp("err0", 8'h00, rb[REG_ERR0]);
		cmp("err1", 8'hFF, rb[REG_ERR1]);
		cmp("err2", 8'h00, rb[REG_ERR2]);
		cmp("eye", eye.sample[1], rb[REG_EYE_DATA]);
		cmp("outctl", 8'h61, rb[REG_OUTCTL]);
		cmp("eye_advance", 8'h01, 8'(n_adv));
		wr(REG_CTRL, 8'h07);
		cbit("arc_oe", 1'b0, arc_oe);
		cbit("eq_adapt", 1'b0, lc.eq_adaptive);
		aud_chk <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			reset(k == 0 ? STRAP_HIGH : STRAP_LOW, k == 0 ? STRAP_FLOAT : STRAP_HIGH);
			dev = (k == 0) ? 8'hBA : 8'hBC;
			tick(2200);
			cbit("eq_adapt", 1'b0, lc.eq_adaptive);
			cbit("eq_gain", k == 0, lc.eq_gain_high);
			cbit("tx_term", k == 0, lc.tx_term_enable);
			wr(REG_EYE_SEL, 8'h02);
			cmp("eye_lane", 8'h02, {6'h00, lane});
		end
		results();
	end
endmodule : tb_video_retimer_lane_config
